// ### hw/tw_cfg.svh
/*
 * Offsets, field positions, reset values and codes of the
 * timing and watchdog unit.
 * Assumes byte addresses on a 24-bit register port.
 */
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TW_ADDR_W 24
`define TW_DATA_W 16
`define TW_OFF_CONFIG 24'hFFFF20
`define TW_OFF_PRESCALER 24'hFFFF22
`define TW_OFF_RELOAD 24'hFFFF24
`define TW_OFF_CTRL 24'hFFFF26
`define TW_OFF_WD_COUNT 24'hFFFF28
`define TW_OFF_WD_MATCH 24'hFFFF2A

// ****************************************************************
// Configuration fields
// ****************************************************************
`define TW_CFG_LOCK_CONFIG 0
`define TW_CFG_LOCK_PRESCALER 1
`define TW_CFG_LOCK_TIMER 2
`define TW_CFG_LOCK_WD_COUNT 3
`define TW_CFG_WD_CLK_SEL 4
`define TW_CFG_MATCH_EN 5
`define TW_CFG_USED_MASK 8'h3F

// ****************************************************************
// Timer control and status fields
// ****************************************************************
`define TW_CSR_RESTART 0
`define TW_CSR_TC 1
`define TW_CSR_INTE 2
`define TW_CSR_WD_LOAD 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define TW_RST_CONFIG 8'h00
`define TW_RST_PRESCALER 3'h0
`define TW_RST_RELOAD 16'hFFFF
`define TW_RST_WD_COUNT 8'h0F
`define TW_WD_MATCH_CODE 8'h5C
`define TW_PRESCALE_W 5

`endif

// ### hw/tw_pkg.sv
/*
 * Types shared by the timing and watchdog unit.
 * Assumes nothing of its surroundings.
 */
package tw_pkg;

    typedef enum logic [1:0] {
        TW_WD_IDLE = 2'b01,
        TW_WD_RUN = 2'b10
    } tw_wd_state_e;

    typedef logic [2:0] tw_mdiv_t;

endpackage

// ### hw/tw_prescaler.sv
/*
 * Prescaler of the timing and watchdog unit: turns slow clock
 * enables into tick enables, dividing by 1, 2, 4, 8, 16 or 32.
 * Assumes slow_en_i is a one-cycle pulse on clk_sys_i.
 */
`timescale 1ns/1ns
`include "tw_cfg.svh"

module tw_prescaler #(
    parameter int CNT_W = `TW_PRESCALE_W
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic slow_en_i,
    input wire logic halt_i,
    input wire tw_pkg::tw_mdiv_t mdiv_i,
    output logic tick_o
);
    import tw_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mask;

    // Reserved settings fall back to the slowest divisor
    always_comb begin
        if (mdiv_i > 3'h5) begin
            mask = {CNT_W{1'b1}};
        end else begin
            mask = CNT_W'((6'h01 << mdiv_i) - 6'h01);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_reg <= '0;
        end else if (slow_en_i && !halt_i) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    assign tick_o = slow_en_i && !halt_i && ((cnt_reg & mask) == mask);
endmodule

// ### hw/tw_timing_watchdog.sv
/*
 * Timing and watchdog unit: prescaler, 16-bit auto-reload periodic
 * timer, 8-bit watchdog and the lockable register file.
 * Assumes slow_clk_en_i is a one-cycle enable on clk_sys_i, and that
 * power_save_i and halt_i come from the power manager on clk_sys_i.
 */
`timescale 1ns/1ns
`include "tw_cfg.svh"

module tw_timing_watchdog (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic slow_clk_en_i,
    input wire logic power_save_i,
    input wire logic halt_i,
    input wire logic [`TW_ADDR_W-1:0] reg_addr_i,
    input wire logic [`TW_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`TW_DATA_W-1:0] reg_rdata_o,
    output logic terminal_pulse_o,
    output logic timer_irq_o,
    output logic wd_error_o,
    output logic wd_running_o
);
    import tw_pkg::*;
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [7:0] config_reg;
    tw_mdiv_t prescaler_reg;
    logic [15:0] reload_reg;
    logic [15:0] timer_reg;
    logic restart_reg;
    logic tc_reg;
    logic inte_reg;
    logic wd_load_reg;
    logic term_reg;
    logic irq_reg;
    logic [7:0] wd_count_reg;
    logic [7:0] wd_cnt_reg;
    tw_wd_state_e wd_state_reg;
    logic wd_fresh_reg;
    logic wd_err_reg;
    logic [`TW_DATA_W-1:0] rdata_reg;
    logic tick;
    logic term_event;
    logic wd_step;
    logic active_wr;
    logic wr_config;
    logic wr_prescaler;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_wd_count;
    logic wr_wd_match;
    logic rd_ctrl;
    logic match_on;
    logic wd_service;
    logic wd_bad_code;
    logic [7:0] wd_service_val;
    logic lock_config;
    logic lock_prescaler;
    logic lock_periodic_timer;
    logic lock_watchdog_count;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign lock_config = config_reg[`TW_CFG_LOCK_CONFIG];
    assign lock_prescaler = config_reg[`TW_CFG_LOCK_PRESCALER];
    assign lock_periodic_timer = config_reg[`TW_CFG_LOCK_TIMER];
    assign lock_watchdog_count = config_reg[`TW_CFG_LOCK_WD_COUNT];
    assign match_on = config_reg[`TW_CFG_MATCH_EN];
    // Halt blocks all access; power save leaves only the match register
    assign active_wr = reg_wr_i && !halt_i && !power_save_i;
    assign wr_config = active_wr && !lock_config
        && (reg_addr_i == `TW_OFF_CONFIG);
    assign wr_prescaler = active_wr && !lock_prescaler
        && (reg_addr_i == `TW_OFF_PRESCALER);
    assign wr_reload = active_wr && !lock_periodic_timer
        && (reg_addr_i == `TW_OFF_RELOAD);
    assign wr_ctrl = active_wr && !lock_periodic_timer
        && (reg_addr_i == `TW_OFF_CTRL);
    assign wr_wd_count = active_wr && !lock_watchdog_count
        && (reg_addr_i == `TW_OFF_WD_COUNT);
    assign wr_wd_match = reg_wr_i && !halt_i
        && (reg_addr_i == `TW_OFF_WD_MATCH);
    assign rd_ctrl = reg_rd_i && !halt_i && !power_save_i
        && !lock_periodic_timer && (reg_addr_i == `TW_OFF_CTRL);

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    tw_prescaler #(
        .CNT_W(`TW_PRESCALE_W)
    ) u_prescaler (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .slow_en_i(slow_clk_en_i),
        .halt_i(halt_i),
        .mdiv_i(prescaler_reg),
        .tick_o(tick)
    );

    // ****************************************************************
    // Configuration and prescaler registers
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            config_reg <= `TW_RST_CONFIG;
        end else if (wr_config) begin
            // Lock bits only ever set; bits 4 and 5 follow the write, bits 7:6 stay zero
            config_reg <= (reg_wdata_i[7:0] & `TW_CFG_USED_MASK)
                | (config_reg & 8'h0F);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            prescaler_reg <= `TW_RST_PRESCALER;
        end else if (wr_prescaler) begin
            prescaler_reg <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reload_reg <= `TW_RST_RELOAD;
        end else if (wr_reload) begin
            // Only read at reload time, so the running count is kept
            reload_reg <= reg_wdata_i;
        end
    end

    // ****************************************************************
    // Timer control and status
    // ****************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            inte_reg <= 1'b0;
        end else if (wr_ctrl) begin
            inte_reg <= reg_wdata_i[`TW_CSR_INTE];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            restart_reg <= 1'b0;
        end else if (wr_ctrl && reg_wdata_i[`TW_CSR_RESTART]) begin
            restart_reg <= 1'b1;
        end else if (tick) begin
            restart_reg <= 1'b0;
        end
    end

    // Terminal event in the same cycle as the clearing read wins
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            tc_reg <= 1'b0;
        end else if (term_event) begin
            tc_reg <= 1'b1;
        end else if (rd_ctrl) begin
            tc_reg <= 1'b0;
        end
    end

    // Pending flag for a watchdog load, held until the next slow clock
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_load_reg <= 1'b0;
        end else if (wr_wd_count || wd_service) begin
            wd_load_reg <= 1'b1;
        end else if (slow_clk_en_i && !halt_i) begin
            wd_load_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // Periodic timer
    // ****************************************************************
    // Terminal event comes on the tick that finds the counter at zero
    assign term_event = tick && !restart_reg && (timer_reg == 16'h0000);

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            timer_reg <= `TW_RST_RELOAD;
        end else if (tick) begin
            if (restart_reg) begin
                timer_reg <= reload_reg;
            end else if (timer_reg == 16'h0000) begin
                timer_reg <= reload_reg;
            end else begin
                timer_reg <= timer_reg - 16'h0001;
            end
        end
    end

    // Pulse stands from the zero tick until the following tick
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            term_reg <= 1'b0;
        end else if (tick) begin
            term_reg <= term_event;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= term_event && inte_reg;
        end
    end
    assign terminal_pulse_o = term_reg;
    assign timer_irq_o = irq_reg;

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    assign wd_step = (wd_state_reg == TW_WD_RUN)
        && (config_reg[`TW_CFG_WD_CLK_SEL] ? tick : term_event);
    // A match write is a service only with the right code in match mode
    assign wd_service = (wr_wd_match && match_on
        && (reg_wdata_i[7:0] == `TW_WD_MATCH_CODE))
        || (wr_wd_count && !match_on);
    assign wd_bad_code = wr_wd_match && match_on
        && (reg_wdata_i[7:0] != `TW_WD_MATCH_CODE);
    assign wd_service_val = (wr_wd_count && !match_on) ?
        reg_wdata_i[7:0] : wd_count_reg;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_count_reg <= `TW_RST_WD_COUNT;
        end else if (wr_wd_count) begin
            wd_count_reg <= reg_wdata_i[7:0];
        end
    end

    // Only reset leaves the running state
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_state_reg <= TW_WD_IDLE;
        end else begin
            case (wd_state_reg)
                TW_WD_IDLE: begin
                    // Match writes are ignored, so no start, with match off
                    if (wr_wd_count || (wr_wd_match && match_on)) begin
                        wd_state_reg <= TW_WD_RUN;
                    end
                end
                TW_WD_RUN: begin
                    wd_state_reg <= TW_WD_RUN;
                end
                default: begin
                    wd_state_reg <= TW_WD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_cnt_reg <= `TW_RST_WD_COUNT;
        end else if (wd_state_reg == TW_WD_IDLE) begin
            if (wr_wd_count) begin
                wd_cnt_reg <= reg_wdata_i[7:0];
            end else if (wr_wd_match && match_on) begin
                wd_cnt_reg <= wd_count_reg;
            end
        end else if (wd_service) begin
            wd_cnt_reg <= wd_service_val;
        end else if (wd_step && wd_cnt_reg != 8'h00) begin
            wd_cnt_reg <= wd_cnt_reg - 8'h01;
        end
    end

    // Set by a start or service, cleared by the next count step
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_fresh_reg <= 1'b0;
        end else if (wd_state_reg == TW_WD_IDLE) begin
            wd_fresh_reg <= wr_wd_count || (wr_wd_match && match_on);
        end else if (wd_service) begin
            wd_fresh_reg <= 1'b1;
        end else if (wd_step) begin
            wd_fresh_reg <= 1'b0;
        end
    end

    // Error is a one-cycle pulse that the reset controller acts on
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wd_err_reg <= 1'b0;
        end else if (wd_state_reg == TW_WD_RUN) begin
            wd_err_reg <= (wd_step && !wd_service
                && wd_cnt_reg <= 8'h01)
                || (wd_service && wd_fresh_reg)
                || wd_bad_code;
        end else begin
            wd_err_reg <= wd_bad_code;
        end
    end
    assign wd_error_o = wd_err_reg;
    assign wd_running_o = (wd_state_reg == TW_WD_RUN);

    // ****************************************************************
    // Read port
    // ****************************************************************
    // Locked, write-only and unmapped locations read as zero
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            rdata_reg <= '0;
            if (!halt_i && !power_save_i) begin
                case (reg_addr_i)
                    `TW_OFF_CONFIG: begin
                        if (!lock_config) begin
                            rdata_reg <= {8'h00, config_reg};
                        end
                    end
                    `TW_OFF_PRESCALER: begin
                        if (!lock_prescaler) begin
                            rdata_reg <= {13'h0000, prescaler_reg};
                        end
                    end
                    `TW_OFF_RELOAD: begin
                        if (!lock_periodic_timer) begin
                            rdata_reg <= reload_reg;
                        end
                    end
                    `TW_OFF_CTRL: begin
                        if (!lock_periodic_timer) begin
                            rdata_reg <= {12'h000, wd_load_reg, inte_reg,
                                tc_reg, restart_reg};
                        end
                    end
                    default: rdata_reg <= '0;
                endcase
            end
        end
    end

    assign reg_rdata_o = rdata_reg;
endmodule

// ### sim/tw_chk.sv
/*
 * Checker for the timing and watchdog unit, bound to its top module.
 * Assumes the synchronous active-high reset of the unit.
 */
`timescale 1ns/1ns
`include "tw_cfg.svh"
module tw_chk (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic slow_clk_en_i,
    input wire logic power_save_i,
    input wire logic halt_i,
    input wire logic [`TW_ADDR_W-1:0] reg_addr_i,
    input wire logic [`TW_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`TW_DATA_W-1:0] reg_rdata_o,
    input wire logic terminal_pulse_o,
    input wire logic timer_irq_o,
    input wire logic wd_error_o,
    input wire logic wd_running_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_irq_one_cycle: assert property (timer_irq_o |=> !timer_irq_o)
        else $error("timer irq longer than one cycle");
    chk_irq_has_terminal: assert property (
        timer_irq_o |-> terminal_pulse_o || $past(terminal_pulse_o))
        else $error("timer irq without terminal pulse");
    chk_wd_run_sticky: assert property (wd_running_o |=> wd_running_o)
        else $error("watchdog stopped without reset");
    // Reset itself is the cause here, so this one is never disabled
    chk_reset_quiet: assert property (disable iff (1'b0)
        $fell(sys_rst_i) |-> !wd_running_o && !wd_error_o && !timer_irq_o
            && !terminal_pulse_o && reg_rdata_o == '0)
        else $error("outputs not quiet after reset");
    chk_idle_silent: assert property (
        !wd_running_o && !$past(wd_running_o) |-> !wd_error_o)
        else $error("watchdog error while never started");
    chk_halt_freeze: assert property (
        halt_i && $past(halt_i) && $past(halt_i, 2) |-> !timer_irq_o
            && !wd_error_o && $stable(terminal_pulse_o)
            && $stable(wd_running_o))
        else $error("activity during halt");
    chk_halt_read: assert property (
        $past(reg_rd_i && halt_i) |-> reg_rdata_o == '0)
        else $error("read data during halt not zero");
    chk_save_read: assert property (
        $past(reg_rd_i && power_save_i) |-> reg_rdata_o == '0)
        else $error("read data in power save not zero");
    cover property (timer_irq_o);
    cover property ($rose(wd_running_o));
    cover property (wd_error_o);
endmodule

bind tw_timing_watchdog tw_chk tw_chk_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .slow_clk_en_i(slow_clk_en_i), .power_save_i(power_save_i),
    .halt_i(halt_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .terminal_pulse_o(terminal_pulse_o), .timer_irq_o(timer_irq_o),
    .wd_error_o(wd_error_o), .wd_running_o(wd_running_o)
);

// ### sim/tb_tw_timing_watchdog.sv
/*
 * Self-checking bench for the timing and watchdog unit.
 * Assumes the checker is bound in from its own file.
 */
`timescale 1ns/1ns
`include "tw_cfg.svh"
module tb_tw_timing_watchdog;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic slow_clk_en_i = 1'b0;
    logic power_save_i = 1'b0;
    logic halt_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [`TW_ADDR_W-1:0] reg_addr_i = '0;
    logic [`TW_DATA_W-1:0] reg_wdata_i = '0;
    logic [`TW_DATA_W-1:0] reg_rdata_o;
    logic terminal_pulse_o, timer_irq_o, wd_error_o, wd_running_o;
    logic rd_seen = 1'b0;
    logic [15:0] rd_q[$];
    int gap_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int irq_cnt = 0;
    int gap = 0;
    int cur, div, snap;
    // Random source, seeded with 94881
    logic [31:0] rnd = 32'h000172A1;

    tw_timing_watchdog tw_timing_watchdog_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .slow_clk_en_i(slow_clk_en_i), .power_save_i(power_save_i),
        .halt_i(halt_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .terminal_pulse_o(terminal_pulse_o), .timer_irq_o(timer_irq_o),
        .wd_error_o(wd_error_o), .wd_running_o(wd_running_o));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // Slow clock every second cycle keeps the longest timer period short
    always @(posedge clk_sys_i) begin
        slow_clk_en_i <= ~slow_clk_en_i;
    end
    // ****************************************************************
    // Result watcher
    // ****************************************************************
    always @(posedge clk_sys_i) begin
        if (rd_seen) begin
            chk_val("rdata", rd_q.pop_front(), reg_rdata_o);
        end
        if (timer_irq_o === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            if (gap_q.size() > 0) begin
                chk_gap("irq gap", gap_q.pop_front(), gap);
            end
        end
        gap <= (timer_irq_o === 1'b1) ? 1 : gap + 1;
        rd_seen <= reg_rd_i;
    end

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h00000000);
    endfunction
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_val(string what, logic [15:0] e, logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic chk_gap(string what, int e, int s);
        n_checks++;
        if (s != e) begin
            miscompares++;
            $display("BAD %s expected %0d seen %0d", what, e, s);
        end
    endtask
    task automatic idle(int n);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic bus(bit w, logic [23:0] a, logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(logic [23:0] a, logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(logic [23:0] a, logic [15:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 16'h0000);
    endtask
    // Which: 0 waits for the timer irq, 1 for the terminal pulse
    task automatic wait_hi(bit which, int lim);
        int k;
        idle(0);
        for (k = 0; k < lim; k++) begin
            @(posedge clk_sys_i);
            if ((which ? terminal_pulse_o : timer_irq_o) === 1'b1) break;
        end
        if (k == lim) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic wait_err(int lim, logic e);
        logic seen;
        seen = 1'b0;
        idle(0);
        repeat (lim) begin
            @(posedge clk_sys_i);
            if (wd_error_o === 1'b1) seen = 1'b1;
        end
        chk_val("wd error", {15'h0000, e}, {15'h0000, seen});
    endtask
    task automatic gap_chk(int rl);
        idle(1);
        gap_q.push_back((rl + 1) * div * 2);
        wait_hi(1'b0, 700);
    endtask
    task automatic do_reset();
        idle(0);
        sys_rst_i <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        idle(2);
    endtask
    task automatic chk_run(logic e);
        chk_val("wd running", {15'h0000, e}, {15'h0000, wd_running_o});
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        do_reset();
        rd(`TW_OFF_CONFIG, 16'h0000);
        rd(`TW_OFF_PRESCALER, 16'h0000);
        rd(`TW_OFF_RELOAD, 16'hFFFF);
        rd(`TW_OFF_CTRL, 16'h0000);
        rd(`TW_OFF_WD_COUNT, 16'h0000);
        rd(24'hFFFF2C, 16'h0000);
        rnd = lfsr(rnd);
        wr(`TW_OFF_RELOAD, rnd[15:0] | 16'h0001);
        rd(`TW_OFF_RELOAD, rnd[15:0] | 16'h0001);
        wr(`TW_OFF_RELOAD, 16'h0003);
        wr(`TW_OFF_CTRL, 16'h0005);
        cur = 3;
        for (int c = 0; c < 8; c++) begin
            div = (c >= 5) ? 32 : (1 << c);
            wr(`TW_OFF_PRESCALER, 16'(c));
            wait_hi(1'b0, 700);
            rd(`TW_OFF_CTRL, 16'h0006);
            wr(`TW_OFF_RELOAD, 16'(5 - cur));
            gap_chk(cur);
            cur = 5 - cur;
            gap_chk(cur);
        end
        halt_i <= 1'b1;
        idle(2);
        snap = irq_cnt;
        rd(`TW_OFF_RELOAD, 16'h0000);
        idle(300);
        chk_val("irq count", 16'(snap), 16'(irq_cnt));
        halt_i <= 1'b0;
        wr(`TW_OFF_CTRL, 16'h0000);
        idle(2);
        snap = irq_cnt;
        wait_hi(1'b1, 700);
        rd(`TW_OFF_CTRL, 16'h0002);
        rd(`TW_OFF_CTRL, 16'h0000);
        idle(4);
        chk_val("irq count", 16'(snap), 16'(irq_cnt));
        power_save_i <= 1'b1;
        wr(`TW_OFF_PRESCALER, 16'h0001);
        rd(`TW_OFF_PRESCALER, 16'h0000);
        power_save_i <= 1'b0;
        rd(`TW_OFF_PRESCALER, 16'h0007);
        wr(`TW_OFF_CONFIG, 16'h0006);
        rd(`TW_OFF_CONFIG, 16'h0006);
        wr(`TW_OFF_CTRL, 16'h0004);
        wr(`TW_OFF_CONFIG, 16'h0000);
        rd(`TW_OFF_CONFIG, 16'h0006);
        rd(`TW_OFF_RELOAD, 16'h0000);
        snap = irq_cnt;
        idle(600);
        chk_val("irq count", 16'(snap), 16'(irq_cnt));
        wr(`TW_OFF_CONFIG, 16'h0001);
        rd(`TW_OFF_CONFIG, 16'h0000);
        do_reset();
        chk_run(1'b0);
        wr(`TW_OFF_CONFIG, 16'h0010);
        wr(`TW_OFF_WD_MATCH, 16'h0011);
        idle(2);
        chk_run(1'b0);
        wr(`TW_OFF_WD_COUNT, 16'h0004);
        wait_err(5, 1'b0);
        chk_run(1'b1);
        wait_err(12, 1'b1);
        do_reset();
        wr(`TW_OFF_WD_COUNT, 16'h0001);
        wait_err(40, 1'b0);
        wr(`TW_OFF_WD_COUNT, 16'h0001);
        wait_err(4, 1'b1);
        do_reset();
        wr(`TW_OFF_CONFIG, 16'h0030);
        wr(`TW_OFF_WD_MATCH, {8'h00, `TW_WD_MATCH_CODE});
        wait_err(10, 1'b0);
        power_save_i <= 1'b1;
        wr(`TW_OFF_WD_MATCH, {8'h00, `TW_WD_MATCH_CODE});
        wait_err(24, 1'b0);
        wr(`TW_OFF_WD_MATCH, 16'h005B);
        wait_err(4, 1'b1);
        power_save_i <= 1'b0;
        do_reset();
        wr(`TW_OFF_CONFIG, 16'h0018);
        wr(`TW_OFF_WD_COUNT, 16'h0004);
        idle(2);
        chk_run(1'b0);
        close_out();
    end
endmodule
